// ---- logic/txdw_pkg.sv ----
// Package for the transmit descriptor word 0 control block.
// Assumes descriptors are eight 32-bit words in system memory, word 0 first.
package txdw_pkg;

  // Words per descriptor and the byte stride between descriptors.
  localparam int unsigned DESC_WORDS = 8;
  localparam logic [31:0] DESC_STRIDE = 32'h0000_0020;

  // Word 0 field positions.
  localparam int unsigned OWN_BIT = 31;
  localparam int unsigned IOC_BIT = 30;
  localparam int unsigned LAST_BIT = 29;
  localparam int unsigned FIRST_BIT = 28;
  localparam int unsigned CRC_DIS_BIT = 27;
  localparam int unsigned PAD_DIS_BIT = 26;
  localparam int unsigned TS_EN_BIT = 25;
  localparam int unsigned CRC_REP_BIT = 24;
  localparam int unsigned CSUM_HI = 23;
  localparam int unsigned CSUM_LO = 22;
  localparam int unsigned RING_END_BIT = 21;
  localparam int unsigned CHAIN_BIT = 20;
  localparam int unsigned VLAN_HI = 19;
  localparam int unsigned VLAN_LO = 18;
  localparam int unsigned TS_CAPT_BIT = 17;

  // Word 1 buffer size fields.
  localparam int unsigned BUF1_HI = 12;
  localparam int unsigned BUF1_LO = 0;
  localparam int unsigned BUF2_HI = 28;
  localparam int unsigned BUF2_LO = 16;

  // Shortest frame before padding, in bytes.
  localparam logic [15:0] MIN_FRAME_BYTES = 16'h0040;

  // Checksum offload modes.
  typedef enum logic [1:0] {
    TXDW_CSUM_OFF = 2'h0,
    TXDW_CSUM_HDR = 2'h1,
    TXDW_CSUM_NOPSEUDO = 2'h2,
    TXDW_CSUM_FULL = 2'h3
  } txdw_csum_t;

  // VLAN tag actions.
  typedef enum logic [1:0] {
    TXDW_VLAN_NONE = 2'h0,
    TXDW_VLAN_STRIP = 2'h1,
    TXDW_VLAN_INSERT = 2'h2,
    TXDW_VLAN_REPLACE = 2'h3
  } txdw_vlan_t;

endpackage

// ---- logic/txdw_desc_mem.sv ----
// Small register store holding the eight words of the current descriptor.
// Assumes one writer and one reader on the same clock.
`timescale 1ns/1ps
module txdw_desc_mem (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire logic [31:0] wr_data,
  input wire logic [2:0] rd_idx,
  output logic [31:0] rd_data
);

  // Storage for one whole descriptor.
  logic [31:0] mem [0:7];

  // Writes land in the addressed word.
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  // Read data come out of a register one cycle after the index.
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data <= 32'h0000_0000;
    end else begin
      rd_data <= mem[rd_idx];
    end
  end

endmodule // txdw_desc_mem

// ---- logic/txdw_ctrl.sv ----
// Transmit descriptor word 0 interpreter: fetches descriptors, drives per-frame MAC controls,
// and writes word 0 back with ownership cleared. Assumes a simple one-word memory port
// whose read data arrive one cycle after the request, and a MAC that pulses SEG_DONE.
`timescale 1ns/1ps
module txdw_ctrl (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic START,
  input wire logic [31:0] LIST_BASE,
  output logic MEM_RD,
  output logic MEM_WR,
  output logic [31:0] MEM_ADDR,
  output logic [31:0] MEM_WDATA,
  input wire logic [31:0] MEM_RDATA,
  output logic FRAME_START,
  output logic [31:0] BUF1_ADDR,
  output logic [31:0] BUF2_ADDR,
  output logic [12:0] BUF1_SIZE,
  output logic [12:0] BUF2_SIZE,
  output logic SEG_FIRST,
  output logic SEG_LAST,
  output logic CRC_APPEND,
  output logic CRC_REPLACE,
  output logic PAD_ENABLE,
  output logic TS_ENABLE,
  output logic [1:0] CSUM_MODE,
  output logic [1:0] VLAN_ACTION,
  input wire logic SEG_DONE,
  input wire logic TS_VALID,
  output logic TX_INTERRUPT,
  output logic IDLE_SUSPENDED,
  output logic SIZE_ERROR
);

  // Fetch and write-back sequence.
  // Encodings are left to the tools; nothing outside sees the state.
  typedef enum logic [2:0] {
    TXDW_IDLE,
    TXDW_FETCH,
    TXDW_WAIT,
    TXDW_CHECK,
    TXDW_SEND,
    TXDW_CLOSE,
    TXDW_NEXT
  } txdw_state_t;

  txdw_state_t state; // Current sequence step.
  logic [31:0] desc_addr; // Byte address of the current descriptor.
  logic [2:0] word_idx; // Word being fetched.
  logic [2:0] store_idx; // Word whose read data arrive now.
  logic rd_pending; // A read result arrives this cycle.
  logic [31:0] rd_word; // Descriptor word read back from the store.
  logic [31:0] word0; // Word 0 captured for decoding.
  logic [31:0] word1; // Word 1 captured for sizes.
  logic [31:0] word2; // Buffer one address.
  logic [31:0] word3; // Buffer two or next descriptor address.
  logic ts_seen; // A timestamp was captured for this frame.

  // Extracts a two-bit field from word 0.
  // Shared by the checksum and VLAN decodes, which sit at different offsets.
  function automatic logic [1:0] field2(input logic [31:0] w, input int unsigned lo);
    field2 = w[lo +: 2];
  endfunction

  // The store keeps all eight words so the chaining address can be reread.
  // Its read port is parked on word 3, so the next-descriptor pointer is always
  // waiting in its output register when the sequence reaches the advance step.
  txdw_desc_mem u_mem (
    .clk(CLOCK),
    .rst(RST),
    .wr_en(rd_pending),
    .wr_idx(store_idx),
    .wr_data(MEM_RDATA),
    .rd_idx(3'h3),
    .rd_data(rd_word)
  );

  // Main sequence: fetch eight words, check ownership, run, write back, advance.
  // START is a level; holding it high simply restarts the ring after each stop.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      // Reset leaves the engine idle until software starts it.
      state <= TXDW_IDLE;
      word_idx <= 3'h0;
    end else begin
      case (state)
        TXDW_IDLE: begin
          // Software kicks the engine after handing over descriptors.
          if (START) begin
            // The first read goes out in the next cycle.
            state <= TXDW_FETCH;
            word_idx <= 3'h0;
          end
        end
        TXDW_FETCH: begin
          // All eight words are read even though only four are used.
          word_idx <= word_idx + 3'h1;
          // The index wraps to zero by itself after word 7.
          if (word_idx == 3'h7) begin
            state <= TXDW_WAIT;
          end
        end
        TXDW_WAIT: begin
          // The last read result is still in flight; one spare cycle lets it land.
          state <= TXDW_CHECK;
        end
        TXDW_CHECK: begin
          // A host-owned descriptor stops the engine untouched.
          // The engine then waits for a fresh start rather than polling the ring,
          // which saves memory traffic at the cost of a software kick.
          if (!word0[txdw_pkg::OWN_BIT]) begin
            state <= TXDW_IDLE;
          end else begin
            // Owned: the segment is handed to the MAC.
            state <= TXDW_SEND;
          end
        end
        TXDW_SEND: begin
          // The MAC reports when the buffers of this descriptor are consumed.
          if (SEG_DONE) begin
            state <= TXDW_CLOSE;
          end
        end
        TXDW_CLOSE: begin
          // Word 0 goes back to memory in this cycle.
          state <= TXDW_NEXT;
        end
        TXDW_NEXT: begin
          // The address logic moves to the next descriptor on this edge.
          state <= TXDW_FETCH;
          word_idx <= 3'h0;
        end
        default: begin
          // Unused encodings fall back to a safe idle.
          state <= TXDW_IDLE;
        end
      endcase
    end
  end

  // Read data of the memory port arrive one cycle after each request.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rd_pending <= 1'b0;
      store_idx <= 3'h0;
    end else begin
      // Only fetch cycles launch reads, so only they produce results.
      rd_pending <= (state == TXDW_FETCH);
      // The index travels along with the result that it names.
      store_idx <= word_idx;
    end
  end

  // Capture the words that steer this block as they arrive.
  // Only the first four words matter here; the rest pass through the store alone.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      // Cleared words read as host-owned, so nothing starts by accident.
      word0 <= 32'h0000_0000;
      word1 <= 32'h0000_0000;
      word2 <= 32'h0000_0000;
      word3 <= 32'h0000_0000;
    end else if (rd_pending) begin
      case (store_idx)
        3'h0: word0 <= MEM_RDATA;
        3'h1: word1 <= MEM_RDATA;
        3'h2: word2 <= MEM_RDATA;
        3'h3: word3 <= MEM_RDATA;
        default: begin
          // Words 4 to 7 carry nothing that this block decodes.
        end
      endcase
    end
  end

  // Next descriptor address: ring end wins, then chaining, else contiguous.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      desc_addr <= 32'h0000_0000;
    end else if (state == TXDW_IDLE && START) begin
      // Every start begins again at the list base.
      desc_addr <= LIST_BASE;
    end else if (state == TXDW_NEXT) begin
      if (word0[txdw_pkg::RING_END_BIT]) begin
        desc_addr <= LIST_BASE;
      end else if (word0[txdw_pkg::CHAIN_BIT]) begin
        // Word 3 held in the descriptor store is the next pointer.
        desc_addr <= rd_word;
      end else begin
        // Without either bit the next descriptor follows this one directly.
        desc_addr <= desc_addr + txdw_pkg::DESC_STRIDE;
      end
    end
  end

  // Memory port: reads during fetch, one write of word 0 when closing.
  always_comb begin
    // The strobes come from exclusive states, so they are never high together.
    MEM_RD = (state == TXDW_FETCH);
    MEM_WR = (state == TXDW_CLOSE);
    if (state == TXDW_FETCH) begin
      // Word addresses step by four bytes across the descriptor.
      MEM_ADDR = desc_addr + {27'h0, word_idx, 2'h0};
    end else begin
      // Outside fetch the address names word 0 for the write-back.
      MEM_ADDR = desc_addr;
    end
  end

  // Write-back word: ownership returned to the host, timestamp status on last segment.
  always_comb begin
    // Every other control bit goes back exactly as the host wrote it.
    MEM_WDATA = word0;
    MEM_WDATA[txdw_pkg::OWN_BIT] = 1'b0;
    // Bit 17 is status, so whatever the host left there is overwritten.
    MEM_WDATA[txdw_pkg::TS_CAPT_BIT] = word0[txdw_pkg::LAST_BIT] & (ts_seen | TS_VALID);
  end

  // Timestamp capture is remembered until the frame's last segment closes.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ts_seen <= 1'b0;
    end else if (state == TXDW_CLOSE && word0[txdw_pkg::LAST_BIT]) begin
      // Set wins: a capture landing in the closing cycle is not lost.
      ts_seen <= TS_VALID;
    end else if (TS_VALID) begin
      // A capture during any segment of the frame is remembered.
      ts_seen <= 1'b1;
    end
  end

  // Per-frame options are latched only from a first-segment descriptor, so middle
  // segments cannot change a frame already under way.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      // Out of reset the MAC appends a CRC and pads, the safest framing.
      CRC_APPEND <= 1'b1;
      CRC_REPLACE <= 1'b0;
      PAD_ENABLE <= 1'b1;
      TS_ENABLE <= 1'b0;
      CSUM_MODE <= txdw_pkg::TXDW_CSUM_OFF;
      VLAN_ACTION <= txdw_pkg::TXDW_VLAN_NONE;
    end else if (state == TXDW_CHECK && word0[txdw_pkg::OWN_BIT] && word0[txdw_pkg::FIRST_BIT]) begin
      // Padding forces a CRC whatever the disable bit says; VLAN edits force one too.
      CRC_APPEND <= !word0[txdw_pkg::CRC_DIS_BIT] || !word0[txdw_pkg::PAD_DIS_BIT]
        || (field2(word0, txdw_pkg::VLAN_LO) != txdw_pkg::TXDW_VLAN_NONE);
      // Replacement applies only with append disabled, and to any retagged frame.
      CRC_REPLACE <= (word0[txdw_pkg::CRC_REP_BIT] && word0[txdw_pkg::CRC_DIS_BIT])
        || (field2(word0, txdw_pkg::VLAN_LO) != txdw_pkg::TXDW_VLAN_NONE);
      PAD_ENABLE <= !word0[txdw_pkg::PAD_DIS_BIT];
      TS_ENABLE <= word0[txdw_pkg::TS_EN_BIT];
      CSUM_MODE <= field2(word0, txdw_pkg::CSUM_LO);
      // Values 01 strip, 10 insert, 11 replace the programmed tag.
      VLAN_ACTION <= field2(word0, txdw_pkg::VLAN_LO);
    end
    // Middle and last segments fall through and keep the options of their frame.
  end

  // Segment information handed to the MAC for every owned descriptor.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      FRAME_START <= 1'b0;
      SEG_FIRST <= 1'b0;
      SEG_LAST <= 1'b0;
      BUF1_ADDR <= 32'h0000_0000;
      BUF2_ADDR <= 32'h0000_0000;
      BUF1_SIZE <= 13'h0000;
      BUF2_SIZE <= 13'h0000;
    end else begin
      // One pulse per owned descriptor, in the cycle after the check.
      FRAME_START <= (state == TXDW_CHECK) && word0[txdw_pkg::OWN_BIT];
      if (state == TXDW_CHECK) begin
        // Segment fields follow every descriptor, not only first segments.
        SEG_FIRST <= word0[txdw_pkg::FIRST_BIT];
        SEG_LAST <= word0[txdw_pkg::LAST_BIT];
        BUF1_ADDR <= word2;
        BUF1_SIZE <= word1[txdw_pkg::BUF1_HI:txdw_pkg::BUF1_LO];
        // A chained descriptor carries no second buffer; its size is ignored.
        if (word0[txdw_pkg::CHAIN_BIT]) begin
          BUF2_ADDR <= 32'h0000_0000;
          BUF2_SIZE <= 13'h0000;
        end else begin
          BUF2_ADDR <= word3;
          BUF2_SIZE <= word1[txdw_pkg::BUF2_HI:txdw_pkg::BUF2_LO];
        end
      end
    end
  end

  // A last segment with both sizes zero is flagged; the engine still closes it.
  // The flag does not stop the transfer; software has to look at it itself.
  always_ff @(posedge CLOCK) begin
    // It stands until the next owned descriptor is checked.
    if (RST) begin
      SIZE_ERROR <= 1'b0;
    end else if (state == TXDW_CHECK && word0[txdw_pkg::OWN_BIT]) begin
      SIZE_ERROR <= word0[txdw_pkg::LAST_BIT]
        && (word1[txdw_pkg::BUF1_HI:txdw_pkg::BUF1_LO] == 13'h0000)
        && (word1[txdw_pkg::BUF2_HI:txdw_pkg::BUF2_LO] == 13'h0000);
    end
  end

  // Completion pulse toward status bit 0, only from a last-segment descriptor.
  // Middle segments never interrupt, even with the completion bit set.
  always_ff @(posedge CLOCK) begin
    // One cycle long; the status register outside holds the bit.
    if (RST) begin
      TX_INTERRUPT <= 1'b0;
    end else begin
      TX_INTERRUPT <= (state == TXDW_CLOSE) && word0[txdw_pkg::IOC_BIT] && word0[txdw_pkg::LAST_BIT];
    end
  end

  // Suspended when the engine waits for the host.
  // It drops while a descriptor is fetched, sent or written back.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      IDLE_SUSPENDED <= 1'b1;
    end else begin
      IDLE_SUSPENDED <= (state == TXDW_IDLE);
    end
  end

endmodule // txdw_ctrl

// ---- verification/txdw_ctrl_checker.sv ----
// Assertions on the port relations of the transmit descriptor word 0 block.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/1ps
module txdw_ctrl_checker (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic MEM_RD,
  input wire logic MEM_WR,
  input wire logic [31:0] MEM_ADDR,
  input wire logic [31:0] MEM_WDATA,
  input wire logic [31:0] MEM_RDATA,
  input wire logic FRAME_START,
  input wire logic SEG_FIRST,
  input wire logic SEG_LAST,
  input wire logic CRC_APPEND,
  input wire logic CRC_REPLACE,
  input wire logic PAD_ENABLE,
  input wire logic TS_ENABLE,
  input wire logic [1:0] CSUM_MODE,
  input wire logic [1:0] VLAN_ACTION,
  input wire logic TX_INTERRUPT
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  // Read strobe delayed twice, so word 0 is caught as it returns.
  logic rd_d, rd_dd;
  logic [31:0] w0; // Word 0 of the descriptor in hand.
  // Word 0 is held until the next fetch, so write-back can be compared with it.
  always_ff @(posedge CLOCK) begin
    rd_d <= RST ? 1'b0 : MEM_RD;
    rd_dd <= RST ? 1'b0 : rd_d;
    if (rd_d && !rd_dd) begin
      w0 <= MEM_RDATA;
    end
  end
  sequence s_fetch;
    MEM_RD [*8] ##1 !MEM_RD;
  endsequence
  sequence s_close_irq;
    MEM_WR && MEM_WDATA[30] && MEM_WDATA[29];
  endsequence
  a_fetch_len: assert property ($rose(MEM_RD) |-> s_fetch)
    else $error("fetch is not eight words");
  a_fetch_step: assert property (MEM_RD && $past(MEM_RD) |-> MEM_ADDR == $past(MEM_ADDR) + 32'h4)
    else $error("fetch address step wrong");
  a_own_clear: assert property (MEM_WR |-> !MEM_WDATA[31] && MEM_WDATA[30:18] == w0[30:18])
    else $error("write-back keeps ownership");
  a_irq_due: assert property (s_close_irq |=> TX_INTERRUPT)
    else $error("missing completion interrupt");
  a_irq_only: assert property (TX_INTERRUPT |-> $past(MEM_WR))
    else $error("interrupt without close");
  a_own_gate: assert property (FRAME_START |-> w0[31] && SEG_FIRST == w0[28] && SEG_LAST == w0[29])
    else $error("frame started wrongly");
  a_opts_load: assert property (FRAME_START && SEG_FIRST |-> CSUM_MODE == w0[23:22]
    && VLAN_ACTION == w0[19:18] && TS_ENABLE == w0[25])
    else $error("offload modes wrong");
  a_crc_pad: assert property (FRAME_START && SEG_FIRST |-> PAD_ENABLE == !w0[26]
    && CRC_APPEND == (!w0[27] || !w0[26] || w0[19:18] != 2'h0)
    && CRC_REPLACE == ((w0[24] && w0[27]) || w0[19:18] != 2'h0))
    else $error("crc or pad control wrong");
  a_opts_hold: assert property ($changed({CRC_APPEND, CRC_REPLACE, PAD_ENABLE, TS_ENABLE, CSUM_MODE, VLAN_ACTION})
    |-> FRAME_START && SEG_FIRST)
    else $error("controls changed off first segment");
endmodule // txdw_ctrl_checker

bind txdw_ctrl txdw_ctrl_checker chk (.CLOCK, .RST, .MEM_RD, .MEM_WR, .MEM_ADDR, .MEM_WDATA, .MEM_RDATA,
  .FRAME_START, .SEG_FIRST, .SEG_LAST, .CRC_APPEND, .CRC_REPLACE, .PAD_ENABLE, .TS_ENABLE, .CSUM_MODE,
  .VLAN_ACTION, .TX_INTERRUPT);

// ---- verification/txdw_host_mem.sv ----
// Host memory model holding the transmit descriptor lists.
// Assumes the bench fills descriptors before each fetch starts.
`timescale 1ns/1ps
module txdw_host_mem (
  input wire logic CLOCK,
  input wire logic MEM_RD,
  input wire logic MEM_WR,
  input wire logic [31:0] MEM_ADDR,
  input wire logic [31:0] MEM_WDATA,
  output logic [31:0] MEM_RDATA
);
  logic [31:0] m [0:63]; // Eight descriptors of eight words each.
  initial begin
    MEM_RDATA = 32'h0;
    for (int i = 0; i < 64; i++) m[i] = 32'h0;
  end
  // Reads answer next cycle; an idle bus toggles so a stale word never passes.
  always @(posedge CLOCK) begin
    if (MEM_RD) begin
      MEM_RDATA <= m[MEM_ADDR[7:2]];
    end else begin
      MEM_RDATA <= ~MEM_RDATA;
    end
    if (MEM_WR) begin
      m[MEM_ADDR[7:2]] <= MEM_WDATA;
    end
  end
endmodule // txdw_host_mem

// ---- verification/tb_top.sv ----
// Self-checking bench for the transmit descriptor word 0 block.
// Assumes the host memory model and the bound checker.
`timescale 1ns/1ps
module tb_top;
  logic CLOCK = 1'b0;
  logic RST, START, SEG_DONE, TS_VALID, MEM_RD, MEM_WR, FRAME_START, SEG_FIRST, SEG_LAST;
  logic CRC_APPEND, CRC_REPLACE, PAD_ENABLE, TS_ENABLE, TX_INTERRUPT, IDLE_SUSPENDED, SIZE_ERROR;
  logic [31:0] LIST_BASE, MEM_ADDR, MEM_WDATA, MEM_RDATA, BUF1_ADDR, BUF2_ADDR, cw;
  logic [12:0] BUF1_SIZE, BUF2_SIZE;
  logic [1:0] CSUM_MODE, VLAN_ACTION;
  int errors = 0;
  int n_tests = 0;
  always #2.5 CLOCK = ~CLOCK;
  txdw_ctrl dut (.CLOCK, .RST, .START, .LIST_BASE, .MEM_RD, .MEM_WR, .MEM_ADDR, .MEM_WDATA, .MEM_RDATA,
    .FRAME_START, .BUF1_ADDR, .BUF2_ADDR, .BUF1_SIZE, .BUF2_SIZE, .SEG_FIRST, .SEG_LAST, .CRC_APPEND,
    .CRC_REPLACE, .PAD_ENABLE, .TS_ENABLE, .CSUM_MODE, .VLAN_ACTION, .SEG_DONE, .TS_VALID, .TX_INTERRUPT,
    .IDLE_SUSPENDED, .SIZE_ERROR);
  txdw_host_mem mem (.CLOCK, .MEM_RD, .MEM_WR, .MEM_ADDR, .MEM_WDATA, .MEM_RDATA);
  task automatic complete_run();
    if (errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  // Bounded wait: 0 for a fetch, 1 for an accepted frame.
  task automatic wait_on(input int k);
    for (int n = 0; n < 60; n++) begin
      if ((k == 0 && MEM_RD === 1'b1) || (k == 1 && FRAME_START === 1'b1)) return;
      @(posedge CLOCK);
      #1;
    end
    errors++;
    complete_run();
  endtask
  // Word 0 is written last so the block never sees a half-built descriptor.
  task automatic put(input logic [7:0] a, input logic [31:0] w0, w1, w2, w3);
    mem.m[a[7:2] + 6'h1] = w1;
    mem.m[a[7:2] + 6'h2] = w2;
    mem.m[a[7:2] + 6'h3] = w3;
    mem.m[a[7:2]] = w0;
  endtask
  task automatic kick();
    @(posedge CLOCK) START <= 1'b1;
    @(posedge CLOCK) START <= 1'b0;
    // Step off the edge so the first fetch cycle is seen as it stands.
    #1;
  endtask
  // Runs one descriptor through fetch, send and close, judging each step.
  task automatic frame(input logic [31:0] a, w0, w1, w2, w3, input logic ts);
    wait_on(0);
    chk(MEM_ADDR === a, "fetch address");
    wait_on(1);
    if (w0[28]) cw = w0;
    chk(SEG_FIRST === w0[28] && SEG_LAST === w0[29], "segment flags");
    chk(CSUM_MODE === cw[23:22] && VLAN_ACTION === cw[19:18] && TS_ENABLE === cw[25], "modes");
    chk(PAD_ENABLE === ~cw[26] && CRC_APPEND === (~cw[27] | ~cw[26] | (cw[19:18] != 2'h0)), "pad or crc");
    chk(CRC_REPLACE === ((cw[24] & cw[27]) | (cw[19:18] != 2'h0)), "crc replace");
    chk(BUF1_ADDR === w2 && BUF1_SIZE === w1[12:0] && BUF2_SIZE === (w0[20] ? 13'h0 : w1[28:16]), "buffers");
    chk(BUF2_ADDR === (w0[20] ? 32'h0 : w3), "second buffer address");
    chk(SIZE_ERROR === (w0[29] && w1[12:0] == 13'h0 && w1[28:16] == 13'h0), "size flag");
    @(posedge CLOCK) TS_VALID <= ts;
    @(posedge CLOCK);
    TS_VALID <= 1'b0;
    SEG_DONE <= 1'b1;
    @(posedge CLOCK);
    SEG_DONE <= 1'b0;
    #1;
    chk(MEM_WR === 1'b1 && MEM_WDATA === {1'b0, w0[30:18], ts & w0[29], w0[16:0]}, "write back");
    @(posedge CLOCK);
    #1;
    chk(TX_INTERRUPT === (w0[30] & w0[29]), "interrupt");
  endtask
  // A descriptor the host still holds is fetched but never used.
  task automatic refused(input logic [31:0] a);
    logic bad;
    bad = 1'b0;
    wait_on(0);
    chk(MEM_ADDR === a, "fetch address");
    repeat (20) begin
      @(posedge CLOCK);
      #1;
      bad = bad | FRAME_START | MEM_WR;
    end
    chk(bad === 1'b0 && IDLE_SUSPENDED === 1'b1, "unowned descriptor used");
  endtask
  // Four frames: sequential, chained, last segment, ring end with chain.
  task automatic sc_ring();
    put(8'h00, 32'hf100_0000, 32'h0000_0040, 32'h0000_1000, 32'h0000_6000);
    put(8'h20, 32'hdf54_0000, 32'h0155_0100, 32'h0000_2000, 32'h0000_0080);
    put(8'h80, 32'he8c8_0000, 32'h0010_0020, 32'h0000_3000, 32'h0000_7000);
    put(8'ha0, 32'hb1b8_0000, 32'h0000_0030, 32'h0000_4000, 32'h0000_0040);
    kick();
    frame(32'h100, 32'hf100_0000, 32'h0000_0040, 32'h0000_1000, 32'h0000_6000, 1'b0);
    frame(32'h120, 32'hdf54_0000, 32'h0155_0100, 32'h0000_2000, 32'h0000_0080, 1'b0);
    frame(32'h80, 32'he8c8_0000, 32'h0010_0020, 32'h0000_3000, 32'h0000_7000, 1'b1);
    frame(32'ha0, 32'hb1b8_0000, 32'h0000_0030, 32'h0000_4000, 32'h0000_0040, 1'b0);
    refused(32'h100);
  endtask
  // Restart from the list base with the last checksum and tag codes.
  task automatic sc_restart();
    put(8'h00, 32'hf4cc_0000, 32'h0000_0044, 32'h0000_5000, 32'h0000_0000);
    kick();
    frame(32'h100, 32'hf4cc_0000, 32'h0000_0044, 32'h0000_5000, 32'h0000_0000, 1'b0);
    refused(32'h120);
  endtask
  initial begin
    RST = 1'b1;
    START = 1'b0;
    // A base away from zero shows that a wrap really returns to the base.
    LIST_BASE = 32'h0000_0100;
    SEG_DONE = 1'b0;
    TS_VALID = 1'b0;
    repeat (10) @(posedge CLOCK);
    #1;
    chk(CRC_APPEND === 1'b1 && PAD_ENABLE === 1'b1 && IDLE_SUSPENDED === 1'b1, "reset levels");
    chk(MEM_RD === 1'b0 && MEM_WR === 1'b0 && FRAME_START === 1'b0 && TX_INTERRUPT === 1'b0, "reset quiet");
    @(posedge CLOCK) RST <= 1'b0;
    sc_ring();
    sc_restart();
    complete_run();
  end
endmodule // tb_top
